// [lsb_exec.sv]
// execution of branches on v/i and data transfer instructions
`timescale 1ns/1ns
module lsb_exec
    import lsb_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] instr,
    input wire logic [15:0] instr_next,
    input wire logic flag_v,
    input wire logic flag_i,
    input wire logic [7:0] dm_rdata,
    input wire logic [4:0] peek_sel,
    output logic [15:0] pc_r,
    output lsb_mem_req_t dm_req_r,
    output logic [7:0] peek_data_r,
    output logic busy_r
);

    typedef enum logic [0:0]
    {
        ST_EXEC = 1'b0,
        ST_SECOND = 1'b1
    } lsb_state_t;

    lsb_state_t state_r;
    lsb_dec_t dec;
    logic [7:0] rf_r [0:31];
    logic [4:0] load_dst_r;
    logic load_pend_r;
    logic [15:0] ptr_val;
    logic [15:0] ptr_inc;
    logic [15:0] ptr_dec;
    logic [15:0] mem_addr_nxt;
    logic flag_hit;
    logic [15:0] koff_ext;
    logic exec_now;

    // ********************************
    // decode
    // ********************************
    lsb_decode u_dec
    (
        .instr(instr),
        .dec(dec)
    );

    assign exec_now = (state_r == ST_EXEC);
    assign ptr_val = {rf_r[dec.ptr_lo + 5'd1], rf_r[dec.ptr_lo]};
    assign ptr_inc = ptr_val + PC_STEP;
    assign ptr_dec = ptr_val - PC_STEP;
    assign koff_ext = {{9{dec.koff[6]}}, dec.koff};
    assign flag_hit = ((dec.flag_sel == FLAG_V_BIT) ? flag_v : flag_i) == dec.flag_want;

    always_comb
    begin
        unique case (dec.amode)
            AM_PREDEC: mem_addr_nxt = ptr_dec; // [RULE_06] [RULE_10]
            AM_ABS: mem_addr_nxt = instr_next; // [RULE_08] [RULE_12]
            default: mem_addr_nxt = ptr_val + {10'h000, dec.disp}; // [RULE_07] [RULE_11]
        endcase
    end

    // ********************************
    // sequencing
    // ********************************
    always_ff @(posedge clk)
    begin
        if (!resetn)
            state_r <= ST_EXEC;
        else if (exec_now && (dec.op == OP_READ || dec.op == OP_WRITE))
            state_r <= ST_SECOND; // [RULE_05] [RULE_09]
        else if (exec_now && dec.op == OP_BRANCH && flag_hit)
            state_r <= ST_SECOND; // [RULE_01] [RULE_03]
        else
            state_r <= ST_EXEC;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            busy_r <= 1'b0;
        else
            busy_r <= exec_now && (dec.op == OP_READ || dec.op == OP_WRITE
                || (dec.op == OP_BRANCH && flag_hit));
    end

    // ********************************
    // program counter
    // ********************************
    always_ff @(posedge clk)
    begin
        if (!resetn)
            pc_r <= PC_RESET;
        else if (exec_now)
        begin
            if (dec.op == OP_BRANCH && flag_hit)
                pc_r <= pc_r + koff_ext + PC_STEP; // [RULE_01] [RULE_02] [RULE_03] [RULE_04]
            else if (dec.amode == AM_ABS && (dec.op == OP_READ || dec.op == OP_WRITE))
                pc_r <= pc_r + PC_STEP2;
            else
                pc_r <= pc_r + PC_STEP; // [RULE_13]
        end
    end

    // ********************************
    // data memory request
    // ********************************
    always_ff @(posedge clk)
    begin
        if (!resetn)
            dm_req_r <= '0;
        else if (exec_now && (dec.op == OP_READ || dec.op == OP_WRITE))
        begin
            dm_req_r.addr <= mem_addr_nxt;
            dm_req_r.wdata <= rf_r[dec.rr];
            dm_req_r.we <= (dec.op == OP_WRITE); // [RULE_09] [RULE_10] [RULE_11] [RULE_12]
            dm_req_r.re <= (dec.op == OP_READ); // [RULE_05] [RULE_06] [RULE_07] [RULE_08]
        end
        else
        begin
            dm_req_r.we <= 1'b0;
            dm_req_r.re <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            load_pend_r <= 1'b0;
            load_dst_r <= 5'h00;
        end
        else
        begin
            load_pend_r <= exec_now && dec.op == OP_READ;
            load_dst_r <= dec.rr;
        end
    end

    // ********************************
    // register file
    // ********************************
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < 32; i++)
                rf_r[i] <= 8'h00;
        end
        else if (load_pend_r)
            rf_r[load_dst_r] <= dm_rdata; // [RULE_05] [RULE_06] [RULE_07] [RULE_08]
        else if (exec_now)
        begin
            unique case (dec.op)
                OP_COPY: rf_r[dec.rd] <= rf_r[dec.rr]; // [RULE_13]
                OP_PAIR:
                begin
                    rf_r[dec.rd] <= rf_r[dec.rr]; // [RULE_13]
                    rf_r[dec.rd + 5'd1] <= rf_r[dec.rr + 5'd1];
                end
                OP_CONST: rf_r[dec.rd] <= dec.imm; // [RULE_13]
                OP_READ, OP_WRITE:
                begin
                    if (dec.amode == AM_POSTINC)
                    begin
                        rf_r[dec.ptr_lo] <= ptr_inc[7:0]; // [RULE_05] [RULE_09]
                        rf_r[dec.ptr_lo + 5'd1] <= ptr_inc[15:8];
                    end
                    else if (dec.amode == AM_PREDEC)
                    begin
                        rf_r[dec.ptr_lo] <= ptr_dec[7:0]; // [RULE_06] [RULE_10]
                        rf_r[dec.ptr_lo + 5'd1] <= ptr_dec[15:8];
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            peek_data_r <= 8'h00;
        else
            peek_data_r <= rf_r[peek_sel];
    end

endmodule

// [lsb_pkg.sv]
// constants and types for the load/store/branch execution block
// How it works
// [RULE_01] With the overflow flag at one, the overflow-high jump adds offset plus one to the pc.
// [RULE_02] With the overflow flag at zero, the overflow-low jump adds offset plus one to the pc.
// [RULE_03] With interrupts enabled, the interrupts-on jump adds offset plus one to the pc.
// [RULE_04] With interrupts disabled, the interrupts-off jump adds offset plus one to the pc.
// [RULE_05] A post-increment pointer read loads the byte at the pointer, then adds one to it.
// [RULE_06] A pre-decrement pointer read first subtracts one, then loads the byte there.
// [RULE_07] An offset read loads the byte at the second or third pointer plus q, pointer kept.
// [RULE_08] An absolute read loads the byte at the address in the second instruction word.
// [RULE_09] A pointer write stores the source, and the post-increment form then adds one.
// [RULE_10] A pre-decrement pointer write subtracts one first, then stores at the new address.
// [RULE_11] An offset write stores the source at the second or third pointer plus q.
// [RULE_12] An absolute write stores the source at the address in the second instruction word.
// [RULE_13] Register copy, pair copy and constant load each finish in one clock, flags untouched.
package lsb_pkg;

    // ********************************
    // opcode patterns
    // ********************************
    localparam logic [5:0] OPC_BRANCH = 6'h3C;   // 1111 0x
    localparam logic [5:0] OPC_COPY = 6'h0B;     // 0010 11
    localparam logic [7:0] OPC_PAIR = 8'h01;     // 0000 0001
    localparam logic [3:0] OPC_CONST = 4'hE;     // 1110
    localparam logic [5:0] OPC_MEM = 6'h24;      // 1001 00
    localparam logic [1:0] OPC_DISP = 2'h2;      // 10q0
    localparam logic [2:0] FLAG_V_BIT = 3'h3;
    localparam logic [2:0] FLAG_I_BIT = 3'h7;

    // pointer low register indices
    localparam logic [4:0] PTR_X_LO = 5'h1A;
    localparam logic [4:0] PTR_Y_LO = 5'h1C;
    localparam logic [4:0] PTR_Z_LO = 5'h1E;

    // low nibble codes of the absolute and pointer forms
    localparam logic [3:0] SUB_ABS = 4'h0;
    localparam logic [3:0] SUB_ZINC = 4'h1;
    localparam logic [3:0] SUB_ZDEC = 4'h2;
    localparam logic [3:0] SUB_YINC = 4'h9;
    localparam logic [3:0] SUB_YDEC = 4'hA;
    localparam logic [3:0] SUB_X = 4'hC;
    localparam logic [3:0] SUB_XINC = 4'hD;
    localparam logic [3:0] SUB_XDEC = 4'hE;

    // cycle counts
    localparam int CYC_MEM = 2;
    localparam int CYC_TAKEN = 2;
    localparam int CYC_SIMPLE = 1;

    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [15:0] PC_STEP2 = 16'h0002;

    typedef enum logic [2:0]
    {
        OP_NONE = 3'b000,
        OP_BRANCH = 3'b001,
        OP_COPY = 3'b010,
        OP_PAIR = 3'b011,
        OP_CONST = 3'b100,
        OP_READ = 3'b101,
        OP_WRITE = 3'b110
    } lsb_op_t;

    typedef enum logic [1:0]
    {
        AM_PLAIN = 2'b00,
        AM_POSTINC = 2'b01,
        AM_PREDEC = 2'b10,
        AM_ABS = 2'b11
    } lsb_amode_t;

    typedef struct packed
    {
        lsb_op_t op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [7:0] imm;
        logic [6:0] koff;
        logic [2:0] flag_sel;
        logic flag_want;
        logic [4:0] ptr_lo;
        lsb_amode_t amode;
        logic [5:0] disp;
    } lsb_dec_t;

    typedef struct packed
    {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } lsb_mem_req_t;

endpackage

// [lsb_decode.sv]
// instruction word decoder
`timescale 1ns/1ns
module lsb_decode
    import lsb_pkg::*;
(
    input wire logic [15:0] instr,
    output lsb_dec_t dec
);

    always_comb
    begin
        dec = '0;
        dec.op = OP_NONE;
        dec.amode = AM_PLAIN;
        dec.rd = instr[8:4];
        dec.rr = {instr[9], instr[3:0]};
        dec.koff = instr[9:3];
        dec.flag_sel = instr[2:0];
        dec.flag_want = ~instr[10];
        dec.imm = {instr[11:8], instr[3:0]};
        dec.disp = {instr[13], instr[11:10], instr[2:0]};
        dec.ptr_lo = instr[3] ? PTR_Y_LO : PTR_Z_LO;
        if (instr[15:10] == OPC_BRANCH || instr[15:10] == (OPC_BRANCH | 6'h01))
        begin
            if (instr[2:0] == FLAG_V_BIT || instr[2:0] == FLAG_I_BIT)
                dec.op = OP_BRANCH;
        end
        else if (instr[15:10] == OPC_COPY)
            dec.op = OP_COPY;
        else if (instr[15:8] == OPC_PAIR)
        begin
            dec.op = OP_PAIR;
            dec.rd = {instr[7:4], 1'b0};
            dec.rr = {instr[3:0], 1'b0};
        end
        else if (instr[15:12] == OPC_CONST)
        begin
            dec.op = OP_CONST;
            dec.rd = {1'b1, instr[7:4]};
        end
        else if (instr[15:14] == OPC_DISP && instr[12] == 1'b0)
        begin
            dec.op = instr[9] ? OP_WRITE : OP_READ;
            dec.rr = instr[8:4];
        end
        else if (instr[15:10] == OPC_MEM)
        begin
            dec.op = instr[9] ? OP_WRITE : OP_READ;
            dec.rr = instr[8:4];
            unique case (instr[3:0])
                SUB_ABS: dec.amode = AM_ABS;
                SUB_ZINC: begin dec.ptr_lo = PTR_Z_LO; dec.amode = AM_POSTINC; end
                SUB_ZDEC: begin dec.ptr_lo = PTR_Z_LO; dec.amode = AM_PREDEC; end
                SUB_YINC: begin dec.ptr_lo = PTR_Y_LO; dec.amode = AM_POSTINC; end
                SUB_YDEC: begin dec.ptr_lo = PTR_Y_LO; dec.amode = AM_PREDEC; end
                SUB_X: dec.ptr_lo = PTR_X_LO;
                SUB_XINC: begin dec.ptr_lo = PTR_X_LO; dec.amode = AM_POSTINC; end
                SUB_XDEC: begin dec.ptr_lo = PTR_X_LO; dec.amode = AM_PREDEC; end
                default: dec.op = OP_NONE;
            endcase
            dec.disp = '0;
        end
    end

endmodule

// [lsb_sram_model.sv]
// data memory model on the far side of the execution block
`timescale 1ns/1ns
module lsb_sram_model
    import lsb_pkg::*;
(
    input wire logic clk,
    input wire lsb_mem_req_t req,
    output logic [7:0] rdata
);
    // ********
    // storage
    // ********
    logic [7:0] mem [256];
    logic [7:0] last_r = 8'h5A;
    initial for (int a = 0; a < 256; a++) mem[a] = 8'(a) ^ 8'hA5;
    // data only while the read stands, scrambled otherwise
    assign rdata = req.re ? mem[req.addr[7:0]] : ~last_r;
    always @(posedge clk)
    begin
        if (req.re)
            last_r <= rdata;
        if (req.we)
            mem[req.addr[7:0]] <= req.wdata;
    end
endmodule

// [lsb_monitor.sv]
// assertion checker for the execution block
`timescale 1ns/1ns
module lsb_monitor
    import lsb_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] instr,
    input wire logic [15:0] instr_next,
    input wire logic flag_v,
    input wire logic flag_i,
    input wire logic [15:0] pc_r,
    input wire lsb_mem_req_t dm_req_r,
    input wire logic busy_r
);
    // ********
    // decode helpers
    // ********
    wire logic [15:0] tgt = pc_r + {{9{instr[9]}}, instr[9:3]} + 16'h0001;
    wire logic [15:0] p1 = pc_r + 16'h0001;
    wire logic [2:0] s = instr[2:0];
    wire logic [1:0] kd = {s[2], instr[10]};
    wire logic brk = !busy_r && instr[15:11] == 5'h1E && (s == 3'h3 || s == 3'h7);
    wire logic tk = brk && ((s == 3'h3 ? flag_v : flag_i) ^ instr[10]);
    wire logic one = !busy_r && instr[15:12] == 4'hE;
    wire logic abs = !busy_r && instr[15:10] == 6'h24 && instr[3:0] == 4'h0;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    vs_take_a: assert property (tk && kd == 2'h0 |=> busy_r && pc_r == $past(tgt))
        else $error("jump target wrong");
    vc_take_a: assert property (tk && kd == 2'h1 |=> busy_r && pc_r == $past(tgt))
        else $error("jump target wrong");
    ie_take_a: assert property (tk && kd == 2'h2 |=> busy_r && pc_r == $past(tgt))
        else $error("jump target wrong");
    id_take_a: assert property (tk && kd == 2'h3 |=> busy_r && pc_r == $past(tgt))
        else $error("jump target wrong");
    no_take_a: assert property (brk && !tk |=> !busy_r && pc_r == $past(p1))
        else $error("fall through wrong");
    const_one_a: assert property (one |=> !busy_r && pc_r == $past(p1))
        else $error("one clock op wrong");
    abs_addr_a: assert property (abs |=> pc_r == $past(pc_r) + 16'h0002 &&
        dm_req_r.addr == $past(instr_next) ##1 !busy_r)
        else $error("absolute access wrong");
    rd_pulse_a: assert property (dm_req_r.re |-> busy_r ##1 !dm_req_r.re)
        else $error("read pulse wrong");
    wr_pulse_a: assert property (dm_req_r.we |-> busy_r ##1 !dm_req_r.we)
        else $error("write pulse wrong");
endmodule
bind lsb_exec lsb_monitor mon (.clk(clk), .resetn(resetn), .instr(instr),
    .instr_next(instr_next), .flag_v(flag_v), .flag_i(flag_i), .pc_r(pc_r),
    .dm_req_r(dm_req_r), .busy_r(busy_r));

// [lsb_exec_test.sv]
// self-checking bench for the execution block
`timescale 1ns/1ns
module lsb_exec_test
    import lsb_pkg::*;
;
    // ********
    // bench
    // ********
    localparam logic [15:0] S1 = 16'h0001;
    logic clk = 0;
    logic resetn = 0;
    logic fv = 0;
    logic fi = 0;
    logic [15:0] ins = 16'h0000;
    logic [15:0] nxt = 16'h0000;
    logic [4:0] psel = 5'h00;
    logic [15:0] pc_r;
    logic [7:0] rdata;
    logic [7:0] peek;
    logic busy;
    lsb_mem_req_t req;
    lsb_mem_req_t rq;
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    lsb_exec uut (.clk(clk), .resetn(resetn), .instr(ins), .instr_next(nxt), .flag_v(fv),
        .flag_i(fi), .dm_rdata(rdata), .peek_sel(psel), .pc_r(pc_r), .dm_req_r(req),
        .peek_data_r(peek), .busy_r(busy));
    lsb_sram_model mdl (.clk(clk), .req(req), .rdata(rdata));
    task automatic results;
        if (num_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            num_errors++;
            results();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            num_errors++;
    endtask
    task automatic op(input logic [15:0] i, n, input logic two, input logic [15:0] st);
        logic [15:0] pc0;
        pc0 = pc_r;
        ins = i;
        nxt = n;
        @(posedge clk);
        #1;
        rq = req;
        chk(busy, two);
        chk(pc_r, pc0 + st);
        if (busy === 1'b1)
        begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic rg(input logic [4:0] r, input logic [7:0] exp);
        ins = 16'h0000;
        psel = r;
        @(posedge clk);
        #1;
        chk(peek, exp);
    endtask
    function automatic logic [15:0] kload(input logic [3:0] d, input logic [7:0] k);
        return {4'hE, k[7:4], d, k[3:0]};
    endfunction
    function automatic logic [15:0] xfer(input logic w, input logic [4:0] d, input logic [3:0] m);
        return {6'h24, w, d, m};
    endfunction
    function automatic logic [15:0] dsp(input logic w, input logic [4:0] d, input logic [5:0] q);
        return {2'h2, q[5], 1'b0, q[4:3], w, d, 1'b1, q[2:0]};
    endfunction
    // ********
    // scenarios
    // ********
    task automatic t_branch;
        logic [6:0] k;
        logic tk;
        for (int f = 0; f < 2; f++)
            for (int c = 0; c < 4; c++)
            begin
                fv = f[0];
                fi = !f[0];
                k = 7'(c * 9 - 10);
                tk = (c[1] ? fi : fv) ^ c[0];
                op({5'h1E, c[0], k, c[1], 2'h3}, 0, tk, tk ? {{9{k[6]}}, k} + S1 : S1);
            end
    endtask
    task automatic t_regs;
        op(kload(4'h0, 8'h3C), 0, 0, S1);
        op(kload(4'h1, 8'h7E), 0, 0, S1);
        op({6'h0B, 1'b1, 5'h02, 4'h0}, 0, 0, S1);
        op({8'h01, 4'h2, 4'h8}, 0, 0, S1);
        rg(5'h02, 8'h3C);
        rg(5'h04, 8'h3C);
        rg(5'h05, 8'h7E);
    endtask
    task automatic t_read;
        op(kload(4'hA, 8'h10), 0, 0, S1);
        op(kload(4'hB, 8'h00), 0, 0, S1);
        op(kload(4'hC, 8'h20), 0, 0, S1);
        op(kload(4'hD, 8'h00), 0, 0, S1);
        op(xfer(0, 5'h05, 4'hD), 0, 1, S1);
        chk(rq.addr, 16'h0010);
        rg(5'h05, 8'hB5);
        rg(5'h1A, 8'h11);
        op(xfer(0, 5'h06, 4'hE), 0, 1, S1);
        rg(5'h06, 8'hB5);
        rg(5'h1A, 8'h10);
        op(dsp(0, 5'h07, 6'h05), 0, 1, S1);
        rg(5'h07, 8'h80);
        rg(5'h1C, 8'h20);
        op(xfer(0, 5'h08, 4'h0), 16'h0040, 1, 16'h0002);
        rg(5'h08, 8'hE5);
    endtask
    task automatic t_write;
        op(kload(4'hE, 8'h30), 0, 0, S1);
        op(kload(4'hF, 8'h00), 0, 0, S1);
        op(xfer(1, 5'h10, 4'hD), 0, 1, S1);
        chk(mdl.mem[8'h10], 8'h3C);
        op(xfer(1, 5'h11, 4'hC), 0, 1, S1);
        chk(mdl.mem[8'h11], 8'h7E);
        rg(5'h1A, 8'h11);
        op(xfer(1, 5'h11, 4'h2), 0, 1, S1);
        chk(mdl.mem[8'h2F], 8'h7E);
        rg(5'h1E, 8'h2F);
        op(dsp(1, 5'h10, 6'h03), 0, 1, S1);
        chk(mdl.mem[8'h23], 8'h3C);
        op(xfer(1, 5'h11, 4'h0), 16'h0050, 1, 16'h0002);
        chk(mdl.mem[8'h50], 8'h7E);
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        resetn = 1;
        chk(pc_r, 16'h0000);
        chk(busy, 1'b0);
        chk(req, '0);
        t_branch();
        t_regs();
        t_read();
        t_write();
        results();
    end
endmodule
